// ==== vsc_defs.svh ====
// register offsets, field positions, reset values and vector numbers
// assumes: included by the package and by the testbench
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define VSC_IDX_PRIO_JTAG_ICD 16'h0886
`define VSC_IDX_PRIO_PTG_A 16'h0888
`define VSC_IDX_PRIO_PTG_B 16'h088a
`define VSC_IDX_TRAP_STAT 16'h08c0
`define VSC_IDX_GLOBAL_CTL 16'h08c2
`define VSC_IDX_DMA_TRAP 16'h08c4
`define VSC_IDX_SOFT_TRAP 16'h08c6
`define VSC_IDX_PEND_VEC 16'h08c8
`define VSC_IDX_EVT_STAT 16'h08ca
`define VSC_IDX_EVT_MASK 16'h08cc
`define VSC_ADDR(idx) ((idx) * 4)

// ------------------------------------------------------------
// reset values and implemented-bit masks
// ------------------------------------------------------------
`define VSC_RST_PRIO_JTAG_ICD 16'h4400
`define VSC_RST_PRIO_PTG_A 16'h4440
`define VSC_RST_PRIO_PTG_B 16'h0444
`define VSC_RST_TRAP_STAT 16'h0000
`define VSC_RST_GLOBAL_CTL 16'h8000
`define VSC_MSK_PRIO_JTAG_ICD 16'h7700
`define VSC_MSK_PRIO_PTG_A 16'h7770
`define VSC_MSK_PRIO_PTG_B 16'h0777
`define VSC_MSK_TRAP_STAT 16'he07e
`define VSC_MSK_GLOBAL_WR 16'ha007
`define VSC_MSK_DMA_TRAP 16'h0030
`define VSC_MSK_SOFT_TRAP 16'h0001
`define VSC_MSK_EVT 12'hfff

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define VSC_BIT_NESTING_DISABLE 15
`define VSC_BIT_GIE 15
`define VSC_BIT_DISABLE_INSTRUCTION_ACTIVE 14
`define VSC_BIT_SOFTWARE_TRAP_TRIGGER 13
`define VSC_EVT_PENDING 11

// ------------------------------------------------------------
// program memory and vector space
// ------------------------------------------------------------
`define VSC_PM_WIDTH 24
`define VSC_PC_STEP 24'h000002
`define VSC_RESET_PC 24'h000000
`define VSC_START_PTR 24'h000002
`define VSC_VEC_LIMIT 24'h000200
`define VSC_VEC_BASE_OFS 9'h002
`define VSC_VEC_ICD 8'h96
`define VSC_VEC_JTAG 8'h97
`define VSC_VEC_PTG_STEP 8'h99
`define VSC_VEC_PTG_WDT 8'h9a
`define VSC_VEC_PTG0 8'h9b
`define VSC_VEC_PTG1 8'h9c
`define VSC_VEC_PTG2 8'h9d
`define VSC_VEC_PTG3 8'h9e

`endif

// ==== vsc_pkg.sv ====
// types shared by the vector space and trap control modules
// assumes: vsc_defs.svh is on the include path
package vsc_pkg;
    `include "vsc_defs.svh"

    typedef struct packed {
        logic [15:0] prio_jtag_icd;
        logic [15:0] prio_ptg_a;
        logic [15:0] prio_ptg_b;
        logic [15:0] trap_stat;
        logic [15:0] global_ctl;
        logic [15:0] dma_trap;
        logic [15:0] soft_trap;
        logic [15:0] pend_vec;
        logic [11:0] evt;
        logic [11:0] evt_mask;
        logic pend_valid;
        logic irq;
        logic int_req;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [23:0] fetch;
        logic [15:0] pm_word;
        logic started;
    } vsc_state_t;

    typedef struct packed {
        logic valid;
        logic [3:0] level;
        logic [7:0] pending_vector_number;
    } vsc_res_t;
endpackage

// ==== vsc_res_if.sv ====
// carrier between the register block and the priority resolver
// assumes: both ends share the system clock
`timescale 1ns/10ps
interface vsc_res_if;
    logic [7:0] req;
    logic [23:0] prio;
    logic valid;
    logic [3:0] level;
    logic [7:0] pending_vector_number;
    modport ctl (output req, output prio, input valid, input level, input pending_vector_number);
    modport res (input req, input prio, output valid, output level, output pending_vector_number);
endinterface

// ==== vsc_resolver.sv ====
// priority resolver: picks the highest pending source and its vector number
// assumes: requests are synchronous levels; result appears one clock later
`timescale 1ns/10ps
module vsc_resolver
    import vsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    vsc_res_if.res rif
);
    vsc_res_t s_r;
    vsc_res_t s_nxt;

    function automatic logic [7:0] vec_of(input logic [2:0] i);
        case (i)
            3'h0: vec_of = `VSC_VEC_ICD;
            3'h1: vec_of = `VSC_VEC_JTAG;
            3'h2: vec_of = `VSC_VEC_PTG_STEP;
            3'h3: vec_of = `VSC_VEC_PTG_WDT;
            3'h4: vec_of = `VSC_VEC_PTG0;
            3'h5: vec_of = `VSC_VEC_PTG1;
            3'h6: vec_of = `VSC_VEC_PTG2;
            default: vec_of = `VSC_VEC_PTG3;
        endcase
    endfunction

    // level 0 means disabled; ties go to the lower vector (ascending scan)
    always_comb
    begin
        logic [2:0] lvl;
        lvl = 3'h0;
        s_nxt = '0;
        for (int i = 0; i < 8; i++)
        begin
            lvl = rif.prio[i*3 +: 3];
            if (rif.req[i] && lvl != 3'h0 && {1'b0, lvl} > s_nxt.level)
            begin
                s_nxt.valid = 1'b1;
                s_nxt.level = {1'b0, lvl};
                s_nxt.pending_vector_number = vec_of(3'(i));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign rif.valid = s_r.valid;
    assign rif.level = s_r.level;
    assign rif.pending_vector_number = s_r.pending_vector_number;

    pend_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.valid |-> (s_r.level != 4'h0 && s_r.level <= 4'h7))
        else $error("pending level out of range");
endmodule // vsc_resolver

// ==== vsc_top.sv ====
// vector space and trap control: apb registers, trap flags, priority
// report, fetch address and program word presentation
// assumes: one 20 MHz clock, apb master on the same clock, sync inputs
`timescale 1ns/10ps

// Summary of operation
// - program locations are 24 bits; upper word's top byte reads zero.
// - lower word sits at even address, upper word at the next odd one.
// - fetch address stays even and steps by two per location.
// - range 0x000000 to 0x000200 holds the fixed reset and trap vectors.
// - fetch starts at zero after reset; jump there uses pointer at 0x000002.
// - trap register holds nesting disable bit 15, accumulator overflow traps 14, 13.
// - math, address, stack, oscillator traps bits 4..1; divide, dma 6, 5.
// - global control holds edge polarities 2..0; resets 8000, enable set.
// - unimplemented bits read zero; resets follow the listed defaults.
module vsc_top
    import vsc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic [10:0] TRAP_EVENT,
    input wire logic DISABLE_INSTRUCTION_ACTIVE_ACTIVE,
    input wire logic [7:0] SRC_REQ,
    output logic IRQ,
    output logic CORE_INT_REQ,
    input wire logic PC_ADVANCE,
    input wire logic PC_BACK,
    input wire logic PC_JUMP,
    input wire logic [23:0] PC_TARGET,
    input wire logic VEC_TAKE,
    output logic [23:0] FETCH_ADDR,
    input wire logic PM_ODD_SEL,
    input wire logic [23:0] PM_LOCATION,
    output logic [15:0] PM_WORD
);
    vsc_state_t s_r;
    vsc_state_t s_nxt;
    vsc_res_if rif ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
        hit = (a == 16'(`VSC_ADDR(idx)));
    endfunction

    function automatic logic [23:0] vec_addr(input logic [7:0] v);
        vec_addr = {14'h0000, 9'({1'b0, v} + `VSC_VEC_BASE_OFS), 1'b0};
    endfunction

    vsc_resolver u_res (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .rif(rif)
    );

    assign rif.req = SRC_REQ;
    assign rif.prio = {s_r.prio_ptg_b[10:8], s_r.prio_ptg_b[6:4], s_r.prio_ptg_b[2:0],
                       s_r.prio_ptg_a[14:12], s_r.prio_ptg_a[10:8], s_r.prio_ptg_a[6:4],
                       s_r.prio_jtag_icd[14:12], s_r.prio_jtag_icd[10:8]};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic setup;
        logic acc;
        logic wr;
        logic rd;
        logic [15:0] wd;
        logic [11:0] evt_in;
        logic [15:0] rdv;
        logic mapped;
        setup = PSEL && !PENABLE;
        acc = PSEL && PENABLE && s_r.pready;
        wr = acc && PWRITE;
        rd = acc && !PWRITE;
        wd = PWDATA[15:0];
        rdv = 16'h0000;
        mapped = 1'b1;
        evt_in = 12'h000;
        s_nxt = s_r;

        // apb: one wait-free access phase, ready raised after setup
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0;
        if (setup)
        begin
            if (hit(PADDR, `VSC_IDX_PRIO_JTAG_ICD))
                rdv = s_r.prio_jtag_icd;
            else if (hit(PADDR, `VSC_IDX_PRIO_PTG_A))
                rdv = s_r.prio_ptg_a;
            else if (hit(PADDR, `VSC_IDX_PRIO_PTG_B))
                rdv = s_r.prio_ptg_b;
            else if (hit(PADDR, `VSC_IDX_TRAP_STAT))
                rdv = s_r.trap_stat & `VSC_MSK_TRAP_STAT;
            else if (hit(PADDR, `VSC_IDX_GLOBAL_CTL))
                rdv = s_r.global_ctl;
            else if (hit(PADDR, `VSC_IDX_DMA_TRAP))
                rdv = s_r.dma_trap;
            else if (hit(PADDR, `VSC_IDX_SOFT_TRAP))
                rdv = s_r.soft_trap;
            else if (hit(PADDR, `VSC_IDX_PEND_VEC))
                rdv = s_r.pend_vec;
            else if (hit(PADDR, `VSC_IDX_EVT_STAT))
                rdv = {4'h0, s_r.evt};
            else if (hit(PADDR, `VSC_IDX_EVT_MASK))
                rdv = {4'h0, s_r.evt_mask};
            else
                mapped = 1'b0;
            s_nxt.prdata = {16'h0000, rdv};
            s_nxt.pslverr = !mapped;
        end

        // software writes; hardware sets are OR-ed in afterwards so they win
        if (wr)
        begin
            if (hit(PADDR, `VSC_IDX_PRIO_JTAG_ICD))
                s_nxt.prio_jtag_icd = wd & `VSC_MSK_PRIO_JTAG_ICD;
            if (hit(PADDR, `VSC_IDX_PRIO_PTG_A))
                s_nxt.prio_ptg_a = wd & `VSC_MSK_PRIO_PTG_A;
            if (hit(PADDR, `VSC_IDX_PRIO_PTG_B))
                s_nxt.prio_ptg_b = wd & `VSC_MSK_PRIO_PTG_B;
            if (hit(PADDR, `VSC_IDX_TRAP_STAT))
                s_nxt.trap_stat = wd & `VSC_MSK_TRAP_STAT;
            if (hit(PADDR, `VSC_IDX_GLOBAL_CTL))
                s_nxt.global_ctl[15:0] = wd & `VSC_MSK_GLOBAL_WR;
            if (hit(PADDR, `VSC_IDX_DMA_TRAP))
                s_nxt.dma_trap = wd & `VSC_MSK_DMA_TRAP;
            if (hit(PADDR, `VSC_IDX_SOFT_TRAP))
                s_nxt.soft_trap = wd & `VSC_MSK_SOFT_TRAP;
            if (hit(PADDR, `VSC_IDX_EVT_MASK))
                s_nxt.evt_mask = wd[11:0] & `VSC_MSK_EVT;
        end
        // a read clears only the bits it returned: a set landing on the
        // setup edge was not reported yet and must survive the access
        if (rd && hit(PADDR, `VSC_IDX_EVT_STAT))
            s_nxt.evt = s_r.evt & ~s_r.prdata[11:0];

        // read-only status follows the core
        s_nxt.global_ctl[`VSC_BIT_DISABLE_INSTRUCTION_ACTIVE] = DISABLE_INSTRUCTION_ACTIVE_ACTIVE;

        // trap flags: osc, stack, addr, math, dma conflict, div0
        s_nxt.trap_stat[6:1] = s_nxt.trap_stat[6:1] | TRAP_EVENT[5:0];
        s_nxt.trap_stat[13] = s_nxt.trap_stat[13] | TRAP_EVENT[6];
        s_nxt.trap_stat[14] = s_nxt.trap_stat[14] | TRAP_EVENT[7];
        s_nxt.dma_trap[5] = s_nxt.dma_trap[5] | TRAP_EVENT[8];
        s_nxt.dma_trap[4] = s_nxt.dma_trap[4] | TRAP_EVENT[9];
        // the software trap trigger raises the soft trap flag
        s_nxt.soft_trap[0] = s_nxt.soft_trap[0] | TRAP_EVENT[10]
                             | s_nxt.global_ctl[`VSC_BIT_SOFTWARE_TRAP_TRIGGER];

        // pending vector report
        s_nxt.pend_valid = rif.valid;
        s_nxt.pend_vec = rif.valid ? {4'h0, rif.level, rif.pending_vector_number} : 16'h0000;
        evt_in = {rif.valid && !s_r.pend_valid, TRAP_EVENT};
        s_nxt.evt = s_nxt.evt | evt_in;
        s_nxt.irq = |(s_nxt.evt & s_nxt.evt_mask);
        // interrupts reach the core only while globally enabled
        s_nxt.int_req = rif.valid && s_r.global_ctl[`VSC_BIT_GIE];

        // fetch address: vector take beats jump beats stepping
        // an odd jump target is forced even rather than refused
        if (VEC_TAKE && rif.valid)
        begin
            s_nxt.fetch = vec_addr(rif.pending_vector_number);
            s_nxt.started = 1'b1;
        end
        else if (PC_JUMP)
        begin
            s_nxt.fetch = {PC_TARGET[23:1], 1'b0};
            s_nxt.started = 1'b1;
        end
        else if (PC_ADVANCE)
        begin
            s_nxt.fetch = s_r.fetch + `VSC_PC_STEP;
            s_nxt.started = 1'b1;
        end
        else if (PC_BACK)
        begin
            s_nxt.fetch = s_r.fetch - `VSC_PC_STEP;
            s_nxt.started = 1'b1;
        end

        // odd address selects the upper word, whose top byte is absent
        s_nxt.pm_word = PM_ODD_SEL ? {8'h00, PM_LOCATION[23:16]}
                                   : PM_LOCATION[15:0];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_r <= '0;
            s_r.prio_jtag_icd <= `VSC_RST_PRIO_JTAG_ICD;
            s_r.prio_ptg_a <= `VSC_RST_PRIO_PTG_A;
            s_r.prio_ptg_b <= `VSC_RST_PRIO_PTG_B;
            s_r.trap_stat <= `VSC_RST_TRAP_STAT;
            s_r.global_ctl <= `VSC_RST_GLOBAL_CTL;
            s_r.fetch <= `VSC_RESET_PC;
        end
        else
            s_r <= s_nxt;
    end

    assign PREADY = s_r.pready;
    assign PRDATA = s_r.prdata;
    assign PSLVERR = s_r.pslverr;
    assign IRQ = s_r.irq;
    assign CORE_INT_REQ = s_r.int_req;
    assign FETCH_ADDR = s_r.fetch;
    assign PM_WORD = s_r.pm_word;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // $past antecedents also need $past(RESET_N): the first edge after release sees reset samples

    // trap register write, as the bus completes it
    logic trap_wr_w;
    assign trap_wr_w = PSEL && PENABLE && PREADY && PWRITE
                       && PADDR == 16'(`VSC_ADDR(`VSC_IDX_TRAP_STAT));

    sequence apb_setup_s;
        PSEL && !PENABLE;
    endsequence

    sequence math_quiet_s;
        TRAP_EVENT[3] ##1 (!trap_wr_w)[*2];
    endsequence

    upper_byte_zero_a: assert property ($past(PM_ODD_SEL) |-> PM_WORD[15:8] == 8'h00)
        else $error("upper program word top byte not zero");
    word_select_a: assert property ($past(RESET_N) && !$past(PM_ODD_SEL)
        |-> PM_WORD == $past(PM_LOCATION[15:0]))
        else $error("even address did not return lower word");
    fetch_even_a: assert property (FETCH_ADDR[0] == 1'b0)
        else $error("fetch address odd");
    pc_step_a: assert property (PC_ADVANCE && !PC_JUMP && !VEC_TAKE
        |=> FETCH_ADDR == $past(FETCH_ADDR) + 24'h000002)
        else $error("fetch did not advance by two");
    vec_range_a: assert property (VEC_TAKE && rif.valid |=> FETCH_ADDR < 24'h000200)
        else $error("vector fetch outside vector space");
    reset_fetch_a: assert property (!s_r.started |-> FETCH_ADDR == 24'h000000)
        else $error("fetch did not start at zero");
    trap_sticky_a: assert property (math_quiet_s
        |-> s_r.trap_stat[4] && $past(s_r.trap_stat[4]))
        else $error("math error trap flag lost");
    ovf_trap_a: assert property (TRAP_EVENT[7] |=> s_r.trap_stat[14])
        else $error("accumulator a overflow flag not set");
    gie_gate_a: assert property (!s_r.global_ctl[15] |=> !CORE_INT_REQ)
        else $error("interrupt passed with global enable clear");
    unimpl_zero_a: assert property (PREADY && !PSLVERR && PENABLE
        |-> PRDATA[31:16] == 16'h0000)
        else $error("unimplemented bits read nonzero");
    irq_follow_a: assert property (IRQ == |(s_r.evt & s_r.evt_mask))
        else $error("interrupt output disagrees with status");

    // ------------------------------------------------------------
    // bus handshake, event, fetch, program word, interrupt and trap checks
    // ------------------------------------------------------------
    // zero wait states: drivers may rely on a fixed two-cycle access
    ready_after_setup_a: assert property (apb_setup_s |=> PREADY)
        else $error("ready did not follow setup");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    // a set landing on the clearing read must survive it
    evt_set_wins_a: assert property (TRAP_EVENT[3] |=> s_r.evt[3])
        else $error("event status lost a set");
    odd_word_a: assert property ($past(RESET_N) && $past(PM_ODD_SEL)
        |-> PM_WORD[7:0] == $past(PM_LOCATION[23:16]))
        else $error("odd address did not return upper byte");
    pc_back_a: assert property (PC_BACK && !PC_ADVANCE && !PC_JUMP && !VEC_TAKE
        |=> FETCH_ADDR == $past(FETCH_ADDR) - `VSC_PC_STEP)
        else $error("fetch did not step back by two");
    jump_even_a: assert property (PC_JUMP && !(VEC_TAKE && rif.valid)
        |=> FETCH_ADDR == {$past(PC_TARGET[23:1]), 1'b0})
        else $error("jump target not word aligned");
    gie_pass_a: assert property (s_r.global_ctl[`VSC_BIT_GIE] && rif.valid
        |=> CORE_INT_REQ)
        else $error("enabled request did not reach the core");
    software_trap_trigger_hold_a: assert property (s_r.global_ctl[`VSC_BIT_SOFTWARE_TRAP_TRIGGER] |=> s_r.soft_trap[0])
        else $error("software trap flag not held");
    slverr_data_a: assert property (PSLVERR |-> PRDATA == 32'h00000000)
        else $error("refused read returned data");
    dma_set_a: assert property (TRAP_EVENT[9] |=> s_r.dma_trap[4])
        else $error("dma overrun flag not set");
    ovb_trap_a: assert property (TRAP_EVENT[6] |=> s_r.trap_stat[13])
        else $error("accumulator b overflow flag not set");
endmodule // vsc_top

// ==== vsc_pm_model.sv ====
// program memory model on the fetch port: one 24-bit location per even address
// assumes: read is combinational, the block registers the word it presents
`timescale 1ns/10ps
module vsc_pm_model
(
    input wire logic [23:0] fetch_addr,
    output logic [23:0] pm_location
);
    logic [23:0] mem [0:511];

    // ------------------------------------------------------------
    // contents
    // ------------------------------------------------------------
    initial
    begin
        // filler differs per location so a wrong index shows up
        for (int i = 0; i < 512; i++)
        begin
            mem[i] = 24'ha50000 | 24'(i);
        end
        // jump code at zero, start address in the next location
        mem[0] = 24'h04c000;
        mem[1] = 24'h000300;
    end

    // odd byte addresses never reach here: location index drops bit 0
    assign pm_location = mem[fetch_addr[9:1]];
endmodule // vsc_pm_model

// ==== vsc_top_bench.sv ====
// self-checking bench for vsc_top: registers, traps, events, priority, fetch
// assumes: vsc_defs.svh on the include path, vsc_pm_model compiled before
`timescale 1ns/10ps
`include "vsc_defs.svh"
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, act, exp); end end
module vsc_top_bench;
    import vsc_pkg::*;
    localparam logic [15:0] A_PJ = 16'(`VSC_ADDR(`VSC_IDX_PRIO_JTAG_ICD));
    localparam logic [15:0] A_PA = 16'(`VSC_ADDR(`VSC_IDX_PRIO_PTG_A));
    localparam logic [15:0] A_PB = 16'(`VSC_ADDR(`VSC_IDX_PRIO_PTG_B));
    localparam logic [15:0] A_TS = 16'(`VSC_ADDR(`VSC_IDX_TRAP_STAT));
    localparam logic [15:0] A_GC = 16'(`VSC_ADDR(`VSC_IDX_GLOBAL_CTL));
    localparam logic [15:0] A_DT = 16'(`VSC_ADDR(`VSC_IDX_DMA_TRAP));
    localparam logic [15:0] A_ST = 16'(`VSC_ADDR(`VSC_IDX_SOFT_TRAP));
    localparam logic [15:0] A_PV = 16'(`VSC_ADDR(`VSC_IDX_PEND_VEC));
    localparam logic [15:0] A_ES = 16'(`VSC_ADDR(`VSC_IDX_EVT_STAT));
    localparam logic [15:0] A_EM = 16'(`VSC_ADDR(`VSC_IDX_EVT_MASK));
    localparam logic [15:0] RA [10] = '{A_PJ, A_PA, A_PB, A_TS, A_GC, A_DT, A_ST, A_PV, A_ES, A_EM};
    localparam logic [15:0] RV [10] = '{16'h4400, 16'h4440, 16'h0444, 16'h0000, 16'h8000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] TA [11] = '{A_TS, A_TS, A_TS, A_TS, A_TS, A_TS, A_TS, A_TS,
        A_DT, A_DT, A_ST};
    localparam logic [15:0] TV [11] = '{16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
        16'h0040, 16'h2000, 16'h4000, 16'h0020, 16'h0010, 16'h0001};
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, core_int_req;
    logic disable_instruction_active_active, pc_advance, pc_back, pc_jump, vec_take, pm_odd_sel;
    logic [15:0] paddr, pm_word, rnd;
    logic [31:0] pwdata, prdata;
    logic [10:0] trap_event;
    logic [7:0] src_req;
    logic [23:0] pc_target, fetch_addr, pm_location;
    logic [32:0] exp_q [$];
    logic [32:0] e;
    int n_fail, compares;

    vsc_top i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .TRAP_EVENT(trap_event), .DISABLE_INSTRUCTION_ACTIVE_ACTIVE(disable_instruction_active_active),
        .SRC_REQ(src_req), .IRQ(irq), .CORE_INT_REQ(core_int_req), .PC_ADVANCE(pc_advance),
        .PC_BACK(pc_back), .PC_JUMP(pc_jump), .PC_TARGET(pc_target), .VEC_TAKE(vec_take),
        .FETCH_ADDR(fetch_addr), .PM_ODD_SEL(pm_odd_sel), .PM_LOCATION(pm_location),
        .PM_WORD(pm_word));
    vsc_pm_model i_mem (.fetch_addr(fetch_addr), .pm_location(pm_location));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // bus and command tasks
    // ------------------------------------------------------------
    task apb(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees ready
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 16'h0000);
    endtask
    task cmd(input logic [3:0] c, input logic [23:0] t, input logic [23:0] x);
        @(posedge sys_clk);
        {vec_take, pc_jump, pc_advance, pc_back} <= c;
        pc_target <= t;
        @(posedge sys_clk);
        {vec_take, pc_jump, pc_advance, pc_back} <= 4'h0;
        @(negedge sys_clk);
        `CHK(fetch_addr, x)
    endtask
    task word(input logic s, input logic [15:0] x);
        @(posedge sys_clk);
        pm_odd_sel <= s;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(pm_word, x)
    endtask
    task pulse(input int i);
        @(posedge sys_clk);
        trap_event <= 11'h001 << i;
        @(posedge sys_clk);
        trap_event <= 11'h000;
        @(negedge sys_clk);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // read data is taken at the edge that completes the access phase
    always @(posedge sys_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    end

    initial
    begin
        #(50 * 40000);
        n_fail++;
        close_out;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, disable_instruction_active_active, pc_advance, pc_back, pc_jump} = 7'h00;
        {vec_take, pm_odd_sel, reset_n} = 3'h0;
        {paddr, pwdata, trap_event, src_req, pc_target} = '0;
        n_fail = 0;
        compares = 0;
        void'($urandom(50));
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        `CHK(fetch_addr, 24'h000000)
        word(1'b0, i_mem.mem[0][15:0]);
        word(1'b1, {8'h00, i_mem.mem[0][23:16]});
        cmd(4'b0010, 24'h000000, 24'h000002);
        word(1'b0, 16'h0300);
        cmd(4'b0100, {8'h00, pm_word}, 24'h000300);
        cmd(4'b0010, 24'h000000, 24'h000302);
        cmd(4'b0001, 24'h000000, 24'h000300);
        cmd(4'b0100, 24'h000301, 24'h000300);
        cmd(4'b0011, 24'h000000, 24'h000302);
        $display("fetch test done");
        for (int i = 0; i < 10; i++)
            rd(RA[i], {17'h00000, RV[i]});
        $display("reset value test done");
        src_req <= 8'hff;
        repeat (4) @(posedge sys_clk);
        rd(A_PV, {17'h00000, 16'h0496});
        `CHK(core_int_req, 1'b1)
        wr_pb: apb(1'b1, A_PB, 16'h0744);
        repeat (3) @(posedge sys_clk);
        rd(A_PV, {17'h00000, 16'h079e});
        cmd(4'b1000, 24'h000000, 24'h000140);
        apb(1'b1, A_GC, 16'h0000);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(core_int_req, 1'b0)
        src_req <= 8'h00;
        apb(1'b1, A_GC, 16'h8000);
        apb(1'b1, A_PB, 16'h0444);
        repeat (3) @(posedge sys_clk);
        rd(A_ES, {17'h00000, 16'h0800});
        $display("priority test done");
        apb(1'b1, A_EM, 16'h0fff);
        for (int i = 0; i < 11; i++)
        begin
            pulse(i);
            `CHK(irq, 1'b1)
            rd(A_ES, {17'h00000, 16'h0001 << i});
            rd(TA[i], {17'h00000, TV[i]});
            apb(1'b1, TA[i], 16'h0000);
        end
        apb(1'b1, A_EM, 16'h0000);
        pulse(3);
        `CHK(irq, 1'b0)
        apb(1'b1, A_EM, 16'h0008);
        @(negedge sys_clk);
        `CHK(irq, 1'b1)
        rd(A_ES, {17'h00000, 16'h0008});
        @(negedge sys_clk);
        `CHK(irq, 1'b0)
        apb(1'b1, A_TS, 16'h0000);
        apb(1'b1, A_GC, 16'ha000);
        rd(A_GC, {17'h00000, 16'ha000});
        rd(A_ST, {17'h00000, 16'h0001});
        apb(1'b1, A_GC, 16'h8000);
        apb(1'b1, A_ST, 16'h0000);
        rd(A_ST, {17'h00000, 16'h0000});
        $display("trap test done");
        repeat (4)
        begin
            rnd = 16'($urandom);
            disable_instruction_active_active <= rnd[3];
            apb(1'b1, A_PJ, rnd);
            rd(A_PJ, {17'h00000, rnd & 16'h7700});
            apb(1'b1, A_PA, ~rnd);
            rd(A_PA, {17'h00000, ~rnd & 16'h7770});
            apb(1'b1, A_PB, rnd);
            rd(A_PB, {17'h00000, rnd & 16'h0777});
            apb(1'b1, A_TS, rnd);
            rd(A_TS, {17'h00000, rnd & 16'he07e});
            apb(1'b1, A_TS, 16'h0000);
            apb(1'b1, A_GC, {13'h1000, rnd[2:0]});
            rd(A_GC, {17'h00000, 1'b1, rnd[3], 11'h000, rnd[2:0]});
            rd(16'h2400, {1'b1, 32'h00000000});
        end
        $display("register test done");
        close_out;
    end
endmodule // vsc_top_bench
